/* shared/imrt_consts.svh */
// Offsets, field layout, reset values and sizes of the inbound message interrupt router
`ifndef IMRT_CONSTS_SVH
`define IMRT_CONSTS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define IMRT_ADDR_W       12
`define IMRT_DATA_W       32
`define IMRT_STAT_OFFSET  12'h0e8
`define IMRT_CTRL_OFFSET  12'h0ec

// ------------------------------------------------------------
// Field layout and reset values
// ------------------------------------------------------------
`define IMRT_NUM_SRC      4
`define IMRT_NUM_LINES    4
`define IMRT_ACT_W        3
`define IMRT_CTRL_W       12
`define IMRT_CTRL_RESET   12'h000
`define IMRT_STAT_RESET   4'h0

`endif

/* shared/imrt_pkg.sv */
// Types of the inbound message interrupt router
package imrt_pkg;

  // Action codes held in each 3-bit field of the action control register
  typedef enum logic [2:0] {
    IMRT_ACT_MASKED = 3'h0,
    IMRT_ACT_MSI    = 3'h1,
    IMRT_ACT_INTA   = 3'h2,
    IMRT_ACT_INTB   = 3'h3,
    IMRT_ACT_INTC   = 3'h4,
    IMRT_ACT_INTD   = 3'h5,
    IMRT_ACT_RSVD6  = 3'h6,
    IMRT_ACT_RSVD7  = 3'h7
  } imrt_action_t;

  // Whether a legacy line's assert message has gone out
  typedef enum logic {
    IMRT_LINE_IDLE     = 1'b0,
    IMRT_LINE_ASSERTED = 1'b1
  } imrt_line_state_t;

endpackage

/* core/imrt_intx_line.sv */
// One legacy virtual-wire line: assert and deassert message sequencing
`timescale 1ns/1ps
`include "imrt_consts.svh"

module imrt_intx_line
  import imrt_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_clk_en,
  input  wire logic i_want,
  input  wire logic i_disable,
  output logic      o_assert,
  output logic      o_deassert,
  output logic      o_level
);

  imrt_line_state_t state;
  imrt_line_state_t next_state;
  logic             next_assert;
  logic             next_deassert;
  logic             next_level;

  // ------------------------------------------------------------
  // Message sequencing
  // ------------------------------------------------------------
  // While disabled the state is held, so a change in demand is only
  // reported once messages are allowed again; nothing is lost or doubled.
  always_comb begin
    next_state    = state;
    next_assert   = 1'b0;
    next_deassert = 1'b0;
    if (!i_disable) begin
      case (state)
        IMRT_LINE_IDLE: begin
          if (i_want) begin
            next_state  = IMRT_LINE_ASSERTED;
            next_assert = 1'b1;
          end
        end
        IMRT_LINE_ASSERTED: begin
          if (!i_want) begin
            next_state    = IMRT_LINE_IDLE;
            next_deassert = 1'b1;
          end
        end
        default: begin
          next_state = IMRT_LINE_IDLE;
        end
      endcase
    end
    next_level = (next_state == IMRT_LINE_ASSERTED);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state      <= IMRT_LINE_IDLE;
      o_assert   <= 1'b0;
      o_deassert <= 1'b0;
      o_level    <= 1'b0;
    end else if (i_clk_en) begin
      state      <= next_state;
      o_assert   <= next_assert;
      o_deassert <= next_deassert;
      o_level    <= next_level;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_assert_on_demand: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_clk_en && i_want && !o_level && !i_disable |=> o_assert && o_level
  ) else $error("line demand did not produce an assert message");

  a_deassert_on_release: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_clk_en && !i_want && o_level && !i_disable |=> o_deassert && !o_level
  ) else $error("line release did not produce a deassert message");

  a_disable_quiet: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_clk_en && i_disable |=> !o_assert && !o_deassert
  ) else $error("legacy message sent while disabled");

  a_line_held: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_clk_en && o_level && i_want |=> o_level && !o_deassert
  ) else $error("line dropped while a mapped source is still set");

endmodule

/* core/imrt_router.sv */
// Inbound message interrupt router: status, action control and interrupt delivery
`timescale 1ns/1ps
`include "imrt_consts.svh"

// Notes on behaviour
// - Control register holds four 3-bit actions at bits 2:0, 5:3, 8:6, 11:9.
// - Act when a status bit sets; legacy lines also act when it clears.
// - Action zero masks the source completely.
// - Action one sends an MSI as the MSI capability describes.
// - Actions two to five drive INTA to INTD: assert on set, deassert on clear.
// - Actions six and seven are reserved; here they behave as masked.
// - An MSI is sent only while the MSI enable bit is set.
// - Legacy assert and deassert messages are suppressed while legacy disable is set.
// - Status bit sets on a far-side outbound message write; write one clears.
module imrt_router
  import imrt_pkg::*;
(
  input  wire logic                      I_REF_CLK,
  input  wire logic                      I_RST,
  input  wire logic                      I_CLK_EN,
  input  wire logic                      I_CFG_WR,
  input  wire logic                      I_CFG_RD,
  input  wire logic [`IMRT_ADDR_W-1:0]   I_CFG_ADDR,
  input  wire logic [`IMRT_DATA_W-1:0]   I_CFG_WDATA,
  input  wire logic [`IMRT_NUM_SRC-1:0]  I_OUTBOUND_MSG_WR,
  input  wire logic                      I_MSI_ENABLE,
  input  wire logic                      I_LEGACY_IRQ_DISABLE,
  output logic      [`IMRT_DATA_W-1:0]   O_CFG_RDATA,
  output logic      [`IMRT_NUM_SRC-1:0]  O_MSI_REQ,
  output logic      [`IMRT_NUM_LINES-1:0] O_INTX_ASSERT,
  output logic      [`IMRT_NUM_LINES-1:0] O_INTX_DEASSERT,
  output logic      [`IMRT_NUM_LINES-1:0] O_INTX_LEVEL
);

  logic [`IMRT_CTRL_W-1:0]    irq_action_control_0;
  logic [`IMRT_CTRL_W-1:0]    next_irq_action_control_0;
  logic [`IMRT_NUM_SRC-1:0]   irq_source_status;
  logic [`IMRT_NUM_SRC-1:0]   next_irq_source_status;
  logic [`IMRT_DATA_W-1:0]    next_rdata;
  logic [`IMRT_NUM_SRC-1:0]   next_msi;
  logic [`IMRT_NUM_LINES-1:0] line_want;
  logic                       wr_ctrl;
  logic                       wr_stat;
  imrt_action_t               act [`IMRT_NUM_SRC];

  assign wr_ctrl = I_CFG_WR && (I_CFG_ADDR == `IMRT_CTRL_OFFSET);
  assign wr_stat = I_CFG_WR && (I_CFG_ADDR == `IMRT_STAT_OFFSET);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // A far-side write in the same cycle as a write-one-clear wins, so an
  // event arriving during the clear is never dropped.
  always_comb begin
    next_irq_action_control_0 = irq_action_control_0;
    if (wr_ctrl) begin
      next_irq_action_control_0 = I_CFG_WDATA[`IMRT_CTRL_W-1:0];
    end
    next_irq_source_status = irq_source_status;
    if (wr_stat) begin
      next_irq_source_status = irq_source_status & ~I_CFG_WDATA[`IMRT_NUM_SRC-1:0];
    end
    next_irq_source_status = next_irq_source_status | I_OUTBOUND_MSG_WR;
    next_rdata = O_CFG_RDATA;
    if (I_CFG_RD) begin
      case (I_CFG_ADDR)
        `IMRT_CTRL_OFFSET: next_rdata = {20'h00000, irq_action_control_0};
        `IMRT_STAT_OFFSET: next_rdata = {28'h0000000, irq_source_status};
        default:           next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      irq_action_control_0 <= `IMRT_CTRL_RESET;
      irq_source_status    <= `IMRT_STAT_RESET;
      O_CFG_RDATA          <= 32'h00000000;
    end else if (I_CLK_EN) begin
      irq_action_control_0 <= next_irq_action_control_0;
      irq_source_status    <= next_irq_source_status;
      O_CFG_RDATA          <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Per-source action decode and MSI generation
  // ------------------------------------------------------------
  // An action rewritten while its status bit is set moves the line demand at once:
  // the old line is deasserted and a newly mapped line asserted; no MSI is sent.
  genvar gi;
  generate
    for (gi = 0; gi < `IMRT_NUM_SRC; gi++) begin : g_src
      assign act[gi] = imrt_action_t'(irq_action_control_0[gi*`IMRT_ACT_W +: `IMRT_ACT_W]);
      // Only the 0-to-1 edge of the status bit sends, never a held bit
      assign next_msi[gi] = !irq_source_status[gi] && next_irq_source_status[gi]
                            && (act[gi] == IMRT_ACT_MSI)
                            && I_MSI_ENABLE;

      a_msi_on_set: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && !irq_source_status[gi] && I_OUTBOUND_MSG_WR[gi]
          && (act[gi] == IMRT_ACT_MSI) && I_MSI_ENABLE |=> O_MSI_REQ[gi]
      ) else $error("status set with msi action did not send an MSI");

      a_msi_enable_gate: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        O_MSI_REQ[gi] && $past(I_CLK_EN) |-> $past(I_MSI_ENABLE)
      ) else $error("MSI sent while MSI enable was clear");

      a_masked_quiet: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && (act[gi] == IMRT_ACT_MASKED) |=> !O_MSI_REQ[gi]
      ) else $error("masked source produced an MSI");

      a_reserved_quiet: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && (act[gi] inside {IMRT_ACT_RSVD6, IMRT_ACT_RSVD7}) |=> !O_MSI_REQ[gi]
      ) else $error("reserved action produced an MSI");

      a_status_set: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && I_OUTBOUND_MSG_WR[gi] |=> irq_source_status[gi]
      ) else $error("outbound message write did not set status");

      // A bit that is already set stays quiet on a repeated far-side write
      a_msi_held_quiet: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && irq_source_status[gi] |=> !O_MSI_REQ[gi]
      ) else $error("MSI sent for a status bit that was already set");

      a_legacy_no_msi: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && (act[gi] inside {IMRT_ACT_INTA, IMRT_ACT_INTB,
                                     IMRT_ACT_INTC, IMRT_ACT_INTD}) |=> !O_MSI_REQ[gi]
      ) else $error("legacy action produced an MSI");

      a_status_clear: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && wr_stat && I_CFG_WDATA[gi] && !I_OUTBOUND_MSG_WR[gi]
          |=> !irq_source_status[gi]
      ) else $error("write one did not clear the status bit");
    end
  endgenerate

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_MSI_REQ <= '0;
    end else if (I_CLK_EN) begin
      O_MSI_REQ <= next_msi;
    end
  end

  // ------------------------------------------------------------
  // Legacy line demand
  // ------------------------------------------------------------
  // A line is wanted while any source mapped to it is still set.
  always_comb begin
    line_want = '0;
    for (int s = 0; s < `IMRT_NUM_SRC; s++) begin
      for (int l = 0; l < `IMRT_NUM_LINES; l++) begin
        if (irq_source_status[s] && (act[s] == imrt_action_t'(3'(IMRT_ACT_INTA) + 3'(l)))) begin
          line_want[l] = 1'b1;
        end
      end
    end
  end

  genvar gl;
  generate
    for (gl = 0; gl < `IMRT_NUM_LINES; gl++) begin : g_line
      imrt_intx_line u_line (
        .i_clk      (I_REF_CLK),
        .i_rst      (I_RST),
        .i_clk_en   (I_CLK_EN),
        .i_want     (line_want[gl]),
        .i_disable  (I_LEGACY_IRQ_DISABLE),
        .o_assert   (O_INTX_ASSERT[gl]),
        .o_deassert (O_INTX_DEASSERT[gl]),
        .o_level    (O_INTX_LEVEL[gl])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_ctrl_write: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && wr_ctrl |=> irq_action_control_0 == $past(I_CFG_WDATA[`IMRT_CTRL_W-1:0])
  ) else $error("control write not stored");

  a_inta_path: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && I_OUTBOUND_MSG_WR[0] && !irq_source_status[0] && !O_INTX_LEVEL[0]
      && !line_want[0] && (act[0] == IMRT_ACT_INTA) && !I_LEGACY_IRQ_DISABLE
      ##1 I_CLK_EN && !I_LEGACY_IRQ_DISABLE && (act[0] == IMRT_ACT_INTA) |=> O_INTX_ASSERT[0]
  ) else $error("source 0 on INTA did not assert the line");

  a_clear_releases: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && O_INTX_LEVEL[0] && (line_want == 4'h0) && !I_LEGACY_IRQ_DISABLE
      |=> O_INTX_DEASSERT[0]
  ) else $error("clearing all sources did not deassert the line");

  a_ctrl_readback: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && I_CFG_RD && (I_CFG_ADDR == `IMRT_CTRL_OFFSET)
      |=> O_CFG_RDATA == {20'h00000, $past(irq_action_control_0)}
  ) else $error("control read did not return the stored actions");

  a_status_readback: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && I_CFG_RD && (I_CFG_ADDR == `IMRT_STAT_OFFSET)
      |=> O_CFG_RDATA == {28'h0000000, $past(irq_source_status)}
  ) else $error("status read did not return the status bits");

  // Disable freezes the line state instead of forcing a deassert
  a_disable_holds_line: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && I_LEGACY_IRQ_DISABLE |=> O_INTX_LEVEL == $past(O_INTX_LEVEL)
  ) else $error("legacy line state changed while disabled");

endmodule

/* tb/imrt_host_model.sv */
// Host side model: virtual-wire state and message counts
`timescale 1ns/1ps
module imrt_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_msi,
  input  wire logic [3:0] i_assert,
  input  wire logic [3:0] i_deassert,
  output logic      [3:0] o_line,
  output int              o_msi_cnt,
  output int              o_err
);
  // ------
  // Message tracking
  // ------
  // A doubled assert or a stray deassert would leave the host wire state wrong
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_line <= 4'h0;
      o_msi_cnt <= 0;
      o_err <= 0;
    end else begin
      if (((i_assert & o_line) | (i_deassert & ~o_line)) != 4'h0) begin
        o_err <= o_err + 1;
      end
      o_line <= (o_line | i_assert) & ~i_deassert;
      o_msi_cnt <= o_msi_cnt + $countones(i_msi);
    end
  end
endmodule

/* tb/imrt_router_test.sv */
// Self-checking bench of the inbound message interrupt router
`timescale 1ns/1ps
`include "imrt_consts.svh"
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
  end \
end
module imrt_router_test;
  localparam logic [11:0] CTRL = `IMRT_CTRL_OFFSET;
  localparam logic [11:0] STAT = `IMRT_STAT_OFFSET;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  msg = 4'h0;
  logic        msi_en = 1'b0;
  logic        dis = 1'b0;
  logic [31:0] rdata;
  logic [3:0]  msi, ast, dea, lvl, hline;
  int          hmsi, herr;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [31:0] seed = 32'ha1c25cca;

  always #12.5 clk = ~clk;

  imrt_router i_imrt_router (
    .I_REF_CLK(clk), .I_RST(rst), .I_CLK_EN(clk_en), .I_CFG_WR(wr),
    .I_CFG_RD(rd), .I_CFG_ADDR(addr), .I_CFG_WDATA(wdata),
    .I_OUTBOUND_MSG_WR(msg), .I_MSI_ENABLE(msi_en), .I_LEGACY_IRQ_DISABLE(dis),
    .O_CFG_RDATA(rdata), .O_MSI_REQ(msi), .O_INTX_ASSERT(ast),
    .O_INTX_DEASSERT(dea), .O_INTX_LEVEL(lvl)
  );
  imrt_host_model i_imrt_host_model (
    .i_clk(clk), .i_rst(rst), .i_msi(msi), .i_assert(ast), .i_deassert(dea),
    .o_line(hline), .o_msi_cnt(hmsi), .o_err(herr)
  );

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  function automatic logic [3:0] line_of(logic [2:0] a, logic d);
    return (a >= 3'h2 && a <= 3'h5 && !d) ? 4'h1 << (a - 3'h2) : 4'h0;
  endfunction

  // One request cycle, then idle; returns just after the taking edge
  task automatic cyc(logic w, logic r, logic [11:0] a, logic [31:0] d, logic [3:0] m);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    msg <= m;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    msg <= 4'h0;
    #1;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic test_done();
    $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Nothing in the run should come near this many cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  // ------
  // Scenarios
  // ------
  initial begin
    logic [2:0] a;
    logic [1:0] s;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cyc(0, 1, CTRL, 0, 0);
    `CHK(rdata, 32'h0)
    cyc(0, 1, STAT, 0, 0);
    `CHK(rdata, 32'h0)
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      a = i[2:0];
      s = seed[1:0];
      @(posedge clk);
      msi_en <= i[3];
      dis <= i[4];
      cyc(1, 0, CTRL, (seed & 32'hfffff000) | (32'(a) << (3 * s)), 0);
      cyc(0, 1, CTRL, 0, 0);
      `CHK(rdata, 32'(a) << (3 * s))
      cyc(0, 0, 0, 0, 4'h1 << s);
      `CHK(msi, (a == 3'h1 && i[3]) ? 4'h1 << s : 4'h0)
      step();
      `CHK(ast, line_of(a, i[4]))
      cyc(0, 1, STAT, 0, 0);
      `CHK(rdata, 32'h1 << s)
      `CHK(hline, line_of(a, i[4]))
      // Status is cleared before the action is changed again
      cyc(1, 0, STAT, 32'h1 << s, 0);
      step();
      `CHK(dea, line_of(a, i[4]))
      `CHK(lvl, 4'h0)
    end
    $display("test action_codes done");
    @(posedge clk);
    msi_en <= 1'b0;
    dis <= 1'b0;
    cyc(1, 0, CTRL, 32'h012, 0);
    cyc(0, 0, 0, 0, 4'h3);
    step();
    `CHK(ast, 4'h1)
    cyc(0, 0, 0, 0, 4'h1);
    step();
    `CHK(ast, 4'h0)
    cyc(1, 0, STAT, 32'h1, 0);
    step();
    `CHK({dea, lvl}, 8'h01)
    cyc(1, 0, STAT, 32'h2, 0);
    step();
    `CHK({dea, lvl}, 8'h10)
    $display("test shared_line done");
    @(posedge clk);
    clk_en <= 1'b0;
    cyc(1, 0, CTRL, 32'h7, 0);
    @(posedge clk);
    clk_en <= 1'b1;
    cyc(1, 0, 12'h0f0, 32'hffffffff, 0);
    cyc(0, 1, CTRL, 0, 0);
    `CHK(rdata, 32'h12)
    cyc(0, 1, 12'h0f0, 0, 0);
    `CHK(rdata, 32'h0)
    `CHK(hmsi, 2)
    `CHK(herr, 0)
    $display("test register_access done");
    test_done();
  end
endmodule
